/* File: rtl/pow2_prescaler.sv */
// Power-of-two enable pulses from the system clock
`default_nettype none
`include "scl_rate_cfg.svh"
module pow2_prescaler import scl_rate_pkg::*; (
   input wire logic sys_clk,
   input wire logic rstn,
   output logic [11:0] tick
);
   logic [10:0] cnt_r;
   logic [10:0] cnt_nxt;
   tick_vec_t tick_r;
   tick_vec_t tick_nxt;

   // Enables, not derived clocks, keep one clock domain
   // One process drives every tap, so the vector has a single driver
   always_comb begin
      cnt_nxt = cnt_r + 11'h001;
      tick_nxt = {`PRE_STAGES{1'b0}};
      tick_nxt[0] = 1'b1;
      for (int k = 1; k < `PRE_STAGES; k++) begin
         tick_nxt[k] = ((cnt_r & 11'((1 << k) - 1)) == 11'((1 << k) - 1));
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         cnt_r <= 11'h000;
         tick_r <= `TICK_RST;
      end else begin
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick = tick_r;
endmodule // pow2_prescaler
`default_nettype wire

/* File: rtl/scl_divider.sv */
// Reloading half-period counter that toggles one bus clock
`default_nettype none
`include "scl_rate_cfg.svh"
module scl_divider import scl_rate_pkg::*; (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic run,
   input wire logic mck_en,
   input wire logic [6:0] div,
   output logic scl
);
   scl_phase_t phase_r;
   scl_phase_t phase_nxt;
   div_val_t cnt_r;
   div_val_t cnt_nxt;
   logic scl_r;
   logic scl_nxt;

   always_comb begin
      phase_nxt = phase_r;
      cnt_nxt = cnt_r;
      if (!run) begin
         phase_nxt = PH_IDLE;
         cnt_nxt = div;
      end else begin
         unique case (phase_r)
            PH_IDLE: begin
               phase_nxt = PH_HIGH;
               cnt_nxt = div;
            end
            PH_HIGH, PH_LOW: begin
               if (mck_en) begin
                  if (cnt_r == 7'h00) begin
                     // Same reload for both halves gives equal phases
                     phase_nxt = (phase_r == PH_HIGH) ? PH_LOW : PH_HIGH;
                     cnt_nxt = div;
                  end else begin
                     cnt_nxt = cnt_r - 7'h01;
                  end
               end
            end
            default: begin
               phase_nxt = PH_IDLE;
               cnt_nxt = div;
            end
         endcase
      end
      scl_nxt = (phase_nxt != PH_LOW);
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         phase_r <= PH_IDLE;
         cnt_r <= 7'h00;
         scl_r <= 1'b1;
      end else begin
         phase_r <= phase_nxt;
         cnt_r <= cnt_nxt;
         scl_r <= scl_nxt;
      end
   end

   assign scl = scl_r;

   reload_toggle_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (run && mck_en && cnt_r == 7'h00 && phase_r != PH_IDLE)
      |=> (cnt_r == $past(div) && scl_r != $past(scl_r)))
      else $error("divider did not reload and toggle on expiry");
endmodule // scl_divider
`default_nettype wire

/* File: rtl/scl_rate_cfg.svh */
// Register offsets, field positions and reset values of the bus clock rate generator
`ifndef SCL_RATE_CFG_SVH
`define SCL_RATE_CFG_SVH

// Register offsets on the plain register port
`define PSEL_OFS 4'h0
`define MODE0_OFS 4'h1
`define MODE1_OFS 4'h2
`define DATA0_OFS 4'h3
`define DATA1_OFS 4'h4
`define START_OFS 4'h5
`define HALT_OFS 4'h6
`define STAT_OFS 4'h7

// Field positions
`define CHOICE_BIT 15
`define DIV_MSB 15
`define DIV_LSB 9
`define PRE_LOW_MSB 3
`define PRE_LOW_LSB 0
`define PRE_HIGH_MSB 7
`define PRE_HIGH_LSB 4

// Limits and sizes
`define PRE_MAX_CODE 4'hB
`define PRE_STAGES 12
`define NUM_CH 2

// Reset values
`define PSEL_RST 16'h0000
`define MODE_RST 16'h0000
`define DATA_RST 16'hFE00
`define TICK_RST 12'h001

`endif

/* File: rtl/scl_rate_pkg.sv */
// Types shared by the bus clock rate generator
`default_nettype none
package scl_rate_pkg;
   typedef logic [15:0] reg_word_t;
   typedef logic [6:0] div_val_t;
   typedef logic [3:0] pre_code_t;
   typedef logic [11:0] tick_vec_t;
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_HIGH = 2'b01,
      PH_LOW = 2'b10
   } scl_phase_t;
endpackage
`default_nettype wire

/* File: rtl/simple_i2c_scl_rate_gen.sv */
// Bus clock rate generator for two simplified two-wire master channels
`default_nettype none
`include "scl_rate_cfg.svh"
module simple_i2c_scl_rate_gen import scl_rate_pkg::*; (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   output logic [1:0] scl_out,
   output logic [1:0] scl_oe
);
   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   reg_word_t psel_r;
   reg_word_t psel_nxt;
   reg_word_t mode_r [`NUM_CH];
   reg_word_t mode_nxt [`NUM_CH];
   reg_word_t data_r [`NUM_CH];
   reg_word_t data_nxt [`NUM_CH];
   logic [1:0] run_r;
   logic [1:0] run_nxt;
   reg_word_t rdata_r;
   reg_word_t rdata_nxt;
   tick_vec_t tick;
   pre_code_t code_sel [`NUM_CH];
   logic [1:0] mck_en;
   logic [1:0] bad_code;
   logic [1:0] div_zero;
   div_val_t div_w [`NUM_CH];
   logic [1:0] scl_w;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler
   pow2_prescaler u_pre (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .tick(tick)
   );

   tick3_period_a: assert property (tick[3] |=> !tick[3] [*7] ##1 tick[3])
      else $error("prescaler tap three is not a one-in-eight pulse");

   ////////////////////////////////////////////////////////////////////////////
   // Operation clock choice per channel
   always_comb begin
      for (int c = 0; c < `NUM_CH; c++) begin
         // Choice bit steers which prescaler field applies
         code_sel[c] = mode_r[c][`CHOICE_BIT] ? psel_r[`PRE_HIGH_MSB:`PRE_HIGH_LSB]
                                              : psel_r[`PRE_LOW_MSB:`PRE_LOW_LSB];
         // Prohibited codes stop the channel clock rather than alias
         bad_code[c] = (code_sel[c] > `PRE_MAX_CODE);
         mck_en[c] = bad_code[c] ? 1'b0 : tick[code_sel[c]];
         div_w[c] = data_r[c][`DIV_MSB:`DIV_LSB];
         div_zero[c] = (div_w[c] == 7'h00);
      end
   end

   choice_steer_a: assert property (
      ((mode_r[0][`CHOICE_BIT] && psel_r[`PRE_HIGH_MSB:`PRE_HIGH_LSB] == 4'h0) ||
       (!mode_r[0][`CHOICE_BIT] && psel_r[`PRE_LOW_MSB:`PRE_LOW_LSB] == 4'h0))
      |-> mck_en[0])
      else $error("selected undivided field does not give every-cycle enable");

   bad_code_stop_a: assert property (
      (code_sel[1] > `PRE_MAX_CODE) [*2] |-> !mck_en[1] && !$past(mck_en[1]))
      else $error("prohibited prescaler code still produced enables");

   half_rate_a: assert property (
      (code_sel[0] == 4'h1 && mck_en[0]) ##1 (code_sel[0] == 4'h1)
      |-> !mck_en[0] ##1 (code_sel[0] != 4'h1 || mck_en[0]))
      else $error("code one does not divide by two");

   ////////////////////////////////////////////////////////////////////////////
   // Register file
   always_comb begin
      psel_nxt = psel_r;
      run_nxt = run_r;
      rdata_nxt = 16'h0000;
      for (int c = 0; c < `NUM_CH; c++) begin
         mode_nxt[c] = mode_r[c];
         data_nxt[c] = data_r[c];
      end
      if (wr) begin
         unique case (addr)
            `PSEL_OFS: psel_nxt = {8'h00, wdata[7:0]};
            `MODE0_OFS: mode_nxt[0] = wdata;
            `MODE1_OFS: mode_nxt[1] = wdata;
            `DATA0_OFS: data_nxt[0] = wdata;
            `DATA1_OFS: data_nxt[1] = wdata;
            `START_OFS: run_nxt = run_r | wdata[1:0];
            // Upper halt bits belong to absent channels and are dropped
            `HALT_OFS: run_nxt = run_r & ~wdata[1:0];
            default: begin
            end
         endcase
      end
      if (rd) begin
         unique case (addr)
            `PSEL_OFS: rdata_nxt = psel_r;
            `MODE0_OFS: rdata_nxt = mode_r[0];
            `MODE1_OFS: rdata_nxt = mode_r[1];
            `DATA0_OFS: rdata_nxt = data_r[0];
            `DATA1_OFS: rdata_nxt = data_r[1];
            `START_OFS: rdata_nxt = {14'h0000, run_r};
            `STAT_OFS: rdata_nxt = {8'h00, div_zero, bad_code, scl_w, run_r};
            default: rdata_nxt = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         psel_r <= `PSEL_RST;
         run_r <= 2'h0;
         rdata_r <= 16'h0000;
         for (int c = 0; c < `NUM_CH; c++) begin
            mode_r[c] <= `MODE_RST;
            data_r[c] <= `DATA_RST;
         end
      end else begin
         psel_r <= psel_nxt;
         run_r <= run_nxt;
         rdata_r <= rdata_nxt;
         for (int c = 0; c < `NUM_CH; c++) begin
            mode_r[c] <= mode_nxt[c];
            data_r[c] <= data_nxt[c];
         end
      end
   end

   assign rdata = rdata_r;

   div_field_a: assert property (wr && addr == `DATA0_OFS |=> div_w[0] == $past(wdata[15:9]))
      else $error("divider not taken from data bits 15 to 9");

   ////////////////////////////////////////////////////////////////////////////
   // Bus clock dividers
   genvar g;
   generate
      for (g = 0; g < `NUM_CH; g++) begin : g_ch
         scl_divider u_div (
            .sys_clk(sys_clk),
            .rstn(rstn),
            .run(run_r[g]),
            .mck_en(mck_en[g]),
            .div(div_w[g]),
            .scl(scl_w[g])
         );
      end
   endgenerate

   // Open drain: only ever pull low, the pull-up makes high
   assign scl_out = 2'h0;
   assign scl_oe = ~scl_w;

   ////////////////////////////////////////////////////////////////////////////
   // Phase length watch on the first channel
   logic scl_d_r;
   logic scl_d_nxt;
   logic [18:0] len_r;
   logic [18:0] len_nxt;
   logic [18:0] prev_len_r;
   logic [18:0] prev_len_nxt;
   logic [1:0] seen_r;
   logic [1:0] seen_nxt;
   logic toggle;

   always_comb begin
      toggle = (scl_w[0] != scl_d_r);
      scl_d_nxt = scl_w[0];
      len_nxt = toggle ? 19'h00001 : len_r + 19'h00001;
      prev_len_nxt = toggle ? len_r : prev_len_r;
      seen_nxt = seen_r;
      if (!run_r[0] || wr) begin
         seen_nxt = 2'h0;
      end else if (toggle && seen_r != 2'h3) begin
         seen_nxt = seen_r + 2'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         scl_d_r <= 1'b1;
         len_r <= 19'h00000;
         prev_len_r <= 19'h00000;
         seen_r <= 2'h0;
      end else begin
         scl_d_r <= scl_d_nxt;
         len_r <= len_nxt;
         prev_len_r <= prev_len_nxt;
         seen_r <= seen_nxt;
      end
   end

   // Skip the first two phases; the first one's start depends on the load cycle
   equal_phases_a: assert property (
      toggle && seen_r == 2'h3 && run_r[0] |-> len_r == prev_len_r)
      else $error("low and high phases differ in length");

   rate_formula_a: assert property (
      toggle && seen_r == 2'h3 && run_r[0] && code_sel[0] == 4'h0
      |-> len_r == {12'h000, div_w[0]} + 19'h00001)
      else $error("half period is not divider plus one operation clocks");

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios worth reaching
   scl_toggle_c: cover property (run_r[0] && toggle && seen_r == 2'h3);
   high_field_c: cover property (run_r[1] && mode_r[1][`CHOICE_BIT] && mck_en[1] && code_sel[1] > 4'h2);
   bad_code_c: cover property (run_r[0] && bad_code[0]);
   halt_all_c: cover property (wr && addr == `HALT_OFS && wdata == 16'h000F && run_r == 2'h3);
endmodule // simple_i2c_scl_rate_gen
`default_nettype wire

/* File: verif/bus_slave_model.sv */
// Pull-up and slave side of the two open-drain bus clock lines
`default_nettype none
module bus_slave_model (
   input wire logic [1:0] scl_out,
   input wire logic [1:0] scl_oe,
   output logic [1:0] scl_line
);
   timeunit 1ns;
   timeprecision 1ns;
   // Released line floats to the pull-up level; these slaves never stretch
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         scl_line[c] = scl_oe[c] ? scl_out[c] : 1'b1;
      end
   end
endmodule // bus_slave_model
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the bus clock rate generator
`default_nettype none
`include "scl_rate_cfg.svh"
module tb import scl_rate_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] addr = 4'h0;
   reg_word_t wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   reg_word_t rdata;
   reg_word_t v;
   logic [1:0] scl_out;
   logic [1:0] scl_oe;
   logic [1:0] scl_line;
   int err_count = 0;
   int cmp_count = 0;
   int ch, cs, lo, hi, dv, by;

   initial forever #25 sys_clk = ~sys_clk;

   simple_i2c_scl_rate_gen dut (.sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .scl_out(scl_out), .scl_oe(scl_oe));
   bus_slave_model slave (.scl_out(scl_out), .scl_oe(scl_oe), .scl_line(scl_line));

   ////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("Checks %0d errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk_word(input string what, input reg_word_t exp, input reg_word_t got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_len(input string what, input int exp, input int got);
      cmp_count++;
      if (got != exp) begin
         err_count++;
         $display("Error %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input reg_word_t d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output reg_word_t d);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      @(negedge sys_clk);
      d = rdata;
   endtask

   task automatic rd_chk(input string what, input logic [3:0] a, input reg_word_t exp);
      reg_word_t d;
      rd_reg(a, d);
      chk_word(what, exp, d);
   endtask

   function automatic int half_len(input int div, input int k);
      return (div + 1) << k;
   endfunction

   // First high phase may be stretched by prescaler alignment, so skip it
   task automatic run_check(input int c, input int div, input int k);
      int n;
      wr_reg(`START_OFS, 16'(1 << c));
      n = 0;
      while (scl_line[c] === 1'b1 && n < 9000) begin
         @(negedge sys_clk);
         n++;
      end
      n = 0;
      while (scl_line[c] === 1'b0 && n < 9000) begin
         @(negedge sys_clk);
         n++;
      end
      chk_len("low phase", half_len(div, k), n);
      n = 0;
      while (scl_line[c] === 1'b1 && n < 9000) begin
         @(negedge sys_clk);
         n++;
      end
      chk_len("high phase", half_len(div, k), n);
      wr_reg(`HALT_OFS, 16'h000F);
      repeat (3) @(negedge sys_clk);
      chk_word("released line", 16'h0001, {15'h0000, scl_line[c]});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (60000) @(posedge sys_clk);
      err_count++;
      $display("Error watchdog expected finish seen hang");
      wrap_up();
   end

   initial begin
      void'($urandom(80));
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      rd_chk("prescale reset", `PSEL_OFS, 16'h0000);
      @(negedge sys_clk);
      chk_word("rdata idle", 16'h0000, rdata);
      rd_chk("mode reset", `MODE0_OFS, 16'h0000);
      rd_chk("divider reset", `DATA0_OFS, 16'hFE00);
      rd_chk("divider reset", `DATA1_OFS, 16'hFE00);
      rd_reg(`STAT_OFS, v);
      chk_word("idle run bits", 16'h0000, v & 16'h0003);
      wr_reg(4'h9, 16'hFFFF);
      rd_chk("unmapped", 4'h9, 16'h0000);
      wr_reg(`PSEL_OFS, 16'hFFFF);
      rd_chk("prescale width", `PSEL_OFS, 16'h00FF);
      // Largest divider at full rate, from reset value
      wr_reg(`PSEL_OFS, 16'h0000);
      run_check(1, 127, 0);
      // Deepest prescaler tap through the upper field
      wr_reg(`PSEL_OFS, 16'h00B0);
      wr_reg(`MODE0_OFS, 16'h8000);
      wr_reg(`DATA0_OFS, 16'h0200);
      run_check(0, 1, 11);
      for (int i = 0; i < 6; i++) begin
         ch = $urandom_range(1, 0);
         cs = $urandom_range(1, 0);
         lo = $urandom_range(3, 0);
         hi = $urandom_range(3, 0);
         dv = $urandom_range(15, 1);
         by = $urandom_range(255, 0);
         wr_reg(`PSEL_OFS, 16'(hi * 16 + lo));
         wr_reg(4'(`MODE0_OFS + ch), 16'(cs << 15));
         wr_reg(4'(`DATA0_OFS + ch), 16'(dv * 512 + by));
         rd_chk("divider word", 4'(`DATA0_OFS + ch), 16'(dv * 512 + by));
         run_check(ch, dv, cs ? hi : lo);
      end
      // Prohibited code freezes the clock; zero divider is flagged
      wr_reg(`PSEL_OFS, 16'h000C);
      wr_reg(`MODE0_OFS, 16'h0000);
      wr_reg(`MODE1_OFS, 16'h8000);
      wr_reg(`DATA1_OFS, 16'h0000);
      wr_reg(`START_OFS, 16'h0001);
      repeat (20) @(posedge sys_clk);
      rd_reg(`STAT_OFS, v);
      chk_word("status flags", 16'h0095, v & 16'h00B5);
      wr_reg(`HALT_OFS, 16'h000F);
      rd_chk("run after halt", `START_OFS, 16'h0000);
      wrap_up();
   end
endmodule // tb
`default_nettype wire
